// ---- shared/ebt_params.svh ----
// Constants for the paired eight-bit timer block.
// Notes on behaviour
// - Competing output actions resolve as toggle, then drive one, then zero.
// - Simultaneous matches A and B apply the higher-priority action.
// - All four action select bits zero disables the output pin.
// - Eight-bit registers are reachable by word and byte accesses.
// - Clock select picks divide by 8, 64, 8192 or external edges.
// - A match applies its action: unchanged, drive 0, drive 1, toggle.
// - Clear select may clear the counter on match A or match B.
// - Clear select may clear the counter on capture B.
// - Capture edge is rising, falling or both.
// - Match fires only when the matched count is incremented away.
// - Capture sets match flag B and loads register B together.
// - Wrap flag sets when the counter goes from all ones to zero.
// - Cascade code in the even channel forms one sixteen-bit counter.
// - In sixteen-bit mode the upper channel matches on all sixteen bits.
// - Sixteen-bit capture loads both B registers, flags both, upper edges.
// - In sixteen-bit mode upper clear select clears both bytes.
// - Upper wrap flag on sixteen-bit wrap, lower on lower-byte wrap.
// - Cascade code in the odd channel counts even channel match A.
// - Capture mode removes compare B behaviour of the even channel.
// - Flags clear only by writing zero after reading one.
// - Clock select codes: stop, three dividers, cascade, three edges.
// - Capture enable in the odd channel turns register B into capture.
`ifndef EBT_PARAMS_SVH
`define EBT_PARAMS_SVH

`define EBT_ADDR_W        8
`define EBT_KIND_COUNT    3'h0
`define EBT_KIND_CONST_A  3'h1
`define EBT_KIND_CONST_B  3'h2
`define EBT_KIND_CTRL     3'h3
`define EBT_KIND_STATUS   3'h4

`define EBT_CKS_STOP      3'h0
`define EBT_CKS_DIV8      3'h1
`define EBT_CKS_DIV64     3'h2
`define EBT_CKS_DIV8192   3'h3
`define EBT_CKS_CASCADE   3'h4
`define EBT_CKS_EXT_RISE  3'h5
`define EBT_CKS_EXT_FALL  3'h6
`define EBT_CKS_EXT_BOTH  3'h7

`define EBT_CLR_NONE      2'h0
`define EBT_CLR_MATCH_A   2'h1
`define EBT_CLR_MATCH_B   2'h2
`define EBT_CLR_CAPTURE   2'h3

`define EBT_ACT_NONE      2'h0
`define EBT_ACT_ZERO      2'h1
`define EBT_ACT_ONE       2'h2
`define EBT_ACT_TOGGLE    2'h3

`define EBT_EDGE_RISE     2'h0
`define EBT_EDGE_FALL     2'h1
`define EBT_EDGE_BOTH     2'h2

`define EBT_PRE_W         13
`define EBT_MASK_DIV8     13'h0007
`define EBT_MASK_DIV64    13'h003F
`define EBT_MASK_DIV8192  13'h1FFF

`define EBT_CTRL_RST      5'h00
`define EBT_CFG_RST       5'h00
`define EBT_CFG2_RST      5'h10
`define EBT_CFG_WMASK     5'h1F
`define EBT_CFG2_WMASK    5'h0F
`define EBT_CNT_MAX       8'hFF

`endif

// ---- shared/ebt_pkg.sv ----
// Types shared by the paired eight-bit timer block.
package ebt_pkg;

   typedef struct packed {
      logic [7:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } ebt_avs_req_t;

   typedef enum logic [1:0] {
      BUS_IDLE   = 2'b01,
      BUS_ANSWER = 2'b10
   } ebt_bus_state_t;

endpackage : ebt_pkg

// ---- src/ebt_timer.sv ----
// Four eight-bit timer channels in two cascadable pairs, Avalon-MM slave.
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`include "ebt_params.svh"

module ebt_timer
   import ebt_pkg::*;
(
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   input  wire ebt_avs_req_t avs_req_i,
   output logic [31:0]       avs_readdata_o,
   output logic              avs_waitrequest_o,
   input  wire logic [1:0]   ext_count_clk_i,
   input  wire logic [1:0]   capture_or_output_pin_i,
   output logic [3:0]        timer_output_pin_o,
   output logic [3:0]        timer_output_oe_n_o
);

   ebt_bus_state_t          bus_r;
   logic [`EBT_PRE_W-1:0]   pre_r;
   logic                    tick8;
   logic                    tick64;
   logic                    tick8k;
   logic                    acc;
   logic                    hit;
   logic [2:0]              kind;
   logic                    pair_sel;
   logic [7:0]              cnt_r [4];
   logic [7:0]              cora_r [4];
   logic [7:0]              corb_r [4];
   logic [4:0]              ctl_r [4];
   logic [4:0]              cfg_r [4];
   logic [2:0]              flag_r [4];
   logic [2:0]              arm_r [4];
   logic [7:0]              rd_byte [4];
   logic [3:0]              inc_w;
   logic [3:0]              ma_w;
   logic [3:0]              mb_w;
   logic [3:0]              clr_w;
   logic [3:0]              ovf_w;
   logic [3:0]              capld_w;
   logic [3:0]              cap_pin_w;
   logic [3:0]              wr_w;
   logic [3:0]              rdcap_w;

   // One wait state on every access: the request is seen, then answered.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         bus_r <= BUS_IDLE;
      end else begin
         case (bus_r)
            BUS_IDLE: begin
               if (avs_req_i.read || avs_req_i.write) begin
                  bus_r <= BUS_ANSWER;
               end
            end
            BUS_ANSWER: begin
               bus_r <= BUS_IDLE;
            end
            default: begin
               bus_r <= BUS_IDLE;
            end
         endcase
      end
   end

   assign avs_waitrequest_o = (avs_req_i.read || avs_req_i.write) &&
                              (bus_r != BUS_ANSWER);
   assign acc      = bus_r == BUS_ANSWER;
   assign kind     = avs_req_i.address[4:2];
   assign pair_sel = avs_req_i.address[5];
   assign hit      = (avs_req_i.address[7:6] == 2'h0) &&
                     (avs_req_i.address[1:0] == 2'h0) &&
                     (kind <= `EBT_KIND_STATUS);

   // Read data is sampled on the request edge so it stands at the answer.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (avs_req_i.read && bus_r == BUS_IDLE) begin
         if (hit) begin
            avs_readdata_o <= pair_sel ? {16'h0000, rd_byte[2], rd_byte[3]}
                                       : {16'h0000, rd_byte[0], rd_byte[1]};
         end else begin
            avs_readdata_o <= 32'h0000_0000;
         end
      end
   end

   // Free-running prescaler; each divided rate is a one-cycle enable.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pre_r <= '0;
      end else begin
         pre_r <= pre_r + 1'b1;
      end
   end

   assign tick8  = (pre_r & `EBT_MASK_DIV8) == `EBT_MASK_DIV8;
   assign tick64 = (pre_r & `EBT_MASK_DIV64) == `EBT_MASK_DIV64;
   assign tick8k = (pre_r & `EBT_MASK_DIV8192) == `EBT_MASK_DIV8192;

   // Cascade and stop give no pulse; the pair logic routes cascade.
   function automatic logic src_fn(input logic [2:0] cks,
                                   input logic r,
                                   input logic f,
                                   input logic t8,
                                   input logic t64,
                                   input logic t8k);
      logic p;
      p = 1'b0;
      case (cks)
         `EBT_CKS_DIV8:     p = t8;
         `EBT_CKS_DIV64:    p = t64;
         `EBT_CKS_DIV8192:  p = t8k;
         `EBT_CKS_EXT_RISE: p = r;
         `EBT_CKS_EXT_FALL: p = f;
         `EBT_CKS_EXT_BOTH: p = r | f;
         default:           p = 1'b0;
      endcase
      return p;
   endfunction : src_fn

   // In eight-bit mode only the odd channel may clear on its own capture.
   function automatic logic clr_fn(input logic [1:0] sel,
                                   input logic ma,
                                   input logic mb,
                                   input logic cap);
      return (sel == `EBT_CLR_MATCH_A && ma) ||
             (sel == `EBT_CLR_MATCH_B && mb) ||
             (sel == `EBT_CLR_CAPTURE && cap);
   endfunction : clr_fn

   genvar gp;
   generate
      for (gp = 0; gp < 2; gp++) begin : g_pair
         localparam int E = 2 * gp;
         localparam int O = 2 * gp + 1;
         logic       ck_s1_r, ck_s2_r, ck_s3_r;
         logic       cp_s1_r, cp_s2_r, cp_s3_r;
         logic       ck_r, ck_f, cp_r, cp_f;
         logic       m16, mcc, stop, capture_mode_enable, cap;
         logic [1:0] esel;
         logic       inc_o_own, inc_e_own;
         logic       eq16a, eq16b, clr16;

         // The first stage feeds only the second; edges use stages two and three.
         always_ff @(posedge clk_i) begin
            if (reset_i) begin
               ck_s1_r <= 1'b0;
               ck_s2_r <= 1'b0;
               ck_s3_r <= 1'b0;
               cp_s1_r <= 1'b0;
               cp_s2_r <= 1'b0;
               cp_s3_r <= 1'b0;
            end else begin
               ck_s1_r <= ext_count_clk_i[gp];
               ck_s2_r <= ck_s1_r;
               ck_s3_r <= ck_s2_r;
               cp_s1_r <= capture_or_output_pin_i[gp];
               cp_s2_r <= cp_s1_r;
               cp_s3_r <= cp_s2_r;
            end
         end

         assign ck_r = ck_s2_r & ~ck_s3_r;
         assign ck_f = ~ck_s2_r & ck_s3_r;
         assign cp_r = cp_s2_r & ~cp_s3_r;
         assign cp_f = ~cp_s2_r & cp_s3_r;

         // Both cascade codes at once stall the pair; that setting is
         // illegal and a stall is safer than guessing a leader.
         assign m16  = ctl_r[E][2:0] == `EBT_CKS_CASCADE;
         assign mcc  = ctl_r[O][2:0] == `EBT_CKS_CASCADE;
         assign stop = m16 & mcc;
         assign capture_mode_enable  = cfg_r[O][4];
         assign esel = m16 ? cfg_r[E][3:2] : cfg_r[O][3:2];

         always_comb begin
            case (esel)
               `EBT_EDGE_RISE: cap = capture_mode_enable & cp_r;
               `EBT_EDGE_FALL: cap = capture_mode_enable & cp_f;
               `EBT_EDGE_BOTH: cap = capture_mode_enable & (cp_r | cp_f);
               default:        cap = 1'b0;
            endcase
         end

         // Neither own source includes cascade, so no loop through matches.
         assign inc_o_own = ~stop & src_fn(ctl_r[O][2:0], ck_r, ck_f,
                                           tick8, tick64, tick8k);
         assign inc_e_own = ~stop & src_fn(ctl_r[E][2:0], ck_r, ck_f,
                                           tick8, tick64, tick8k);
         // Equality uses the live counts, so byte writes move the
         // match point at once.
         assign eq16a = {cnt_r[E], cnt_r[O]} == {cora_r[E], cora_r[O]};
         assign eq16b = {cnt_r[E], cnt_r[O]} == {corb_r[E], corb_r[O]};

         // The upper byte steps when the lower byte wraps.
         assign inc_w[E] = m16 ? (inc_o_own && cnt_r[O] == `EBT_CNT_MAX)
                               : inc_e_own;
         assign inc_w[O] = mcc ? ma_w[E] : inc_o_own;

         // Matches fire on the increment that leaves the matching count.
         assign ma_w[E] = m16 ? (eq16a & inc_o_own)
                              : (cnt_r[E] == cora_r[E]) & inc_w[E];
         assign mb_w[E] = ~capture_mode_enable & (m16 ? (eq16b & inc_o_own)
                              : (cnt_r[E] == corb_r[E]) & inc_w[E]);
         assign ma_w[O] = (cnt_r[O] == cora_r[O]) & inc_w[O];
         assign mb_w[O] = ~capture_mode_enable & (cnt_r[O] == corb_r[O]) & inc_w[O];

         assign clr16 = clr_fn(ctl_r[E][4:3], ma_w[E], mb_w[E], cap);
         assign clr_w[E] = m16 ? clr16
                               : clr_fn(ctl_r[E][4:3], ma_w[E], mb_w[E],
                                        1'b0);
         assign clr_w[O] = m16 ? clr16
                               : clr_fn(ctl_r[O][4:3], ma_w[O], mb_w[O],
                                        cap);

         // A clear on the wrap edge suppresses the wrap flag.
         assign ovf_w[E] = m16 ? (inc_o_own & ~clr16 &&
                                  {cnt_r[E], cnt_r[O]} == 16'hFFFF)
                               : (inc_w[E] & ~clr_w[E] &&
                                  cnt_r[E] == `EBT_CNT_MAX);
         assign ovf_w[O] = inc_w[O] & ~clr_w[O] &&
                           cnt_r[O] == `EBT_CNT_MAX;

         // Register B takes the pre-clear count: both update on one edge.
         assign capld_w[O] = cap;
         assign capld_w[E] = cap & m16;
         assign cap_pin_w[O] = capture_mode_enable;
         assign cap_pin_w[E] = 1'b0;
      end
   endgenerate

   // Per-channel registers, flags and pin logic.
   genvar gc;
   generate
      for (gc = 0; gc < 4; gc++) begin : g_chan
         localparam int        P  = gc / 2;
         localparam bit        OD = bit'(gc % 2);
         localparam logic [4:0] CFG_RST = (gc == 2) ? `EBT_CFG2_RST
                                                    : `EBT_CFG_RST;
         localparam logic [4:0] CFG_WM  = (gc == 2) ? `EBT_CFG2_WMASK
                                                    : `EBT_CFG_WMASK;
         logic [7:0] wdat;
         logic       sel;
         logic [1:0] act_a, act_b, act;
         logic [2:0] set_f, sw_clr;

         // Even channel sits in the upper byte lane, odd in the lower.
         assign sel  = hit && pair_sel == P[0] &&
                       avs_req_i.byteenable[OD ? 0 : 1];
         assign wdat = OD ? avs_req_i.writedata[7:0]
                          : avs_req_i.writedata[15:8];
         // Writes land on the answer edge, when the master sees it taken.
         assign wr_w[gc]    = acc & avs_req_i.write & sel;
         assign rdcap_w[gc] = avs_req_i.read & (bus_r == BUS_IDLE) & sel &
                              (kind == `EBT_KIND_STATUS);

         // The kind field picks the byte; lanes merge at the port.
         always_comb begin
            case (kind)
               `EBT_KIND_COUNT:   rd_byte[gc] = cnt_r[gc];
               `EBT_KIND_CONST_A: rd_byte[gc] = cora_r[gc];
               `EBT_KIND_CONST_B: rd_byte[gc] = corb_r[gc];
               `EBT_KIND_CTRL:    rd_byte[gc] = {3'h0, ctl_r[gc]};
               `EBT_KIND_STATUS:  rd_byte[gc] = {flag_r[gc], cfg_r[gc]};
               default:           rd_byte[gc] = 8'h00;
            endcase
         end

         // Clear beats a write; a write beats an increment.
         always_ff @(posedge clk_i) begin
            if (reset_i) begin
               cnt_r[gc] <= 8'h00;
            end else if (clr_w[gc]) begin
               cnt_r[gc] <= 8'h00;
            end else if (wr_w[gc] && kind == `EBT_KIND_COUNT) begin
               cnt_r[gc] <= wdat;
            end else if (inc_w[gc]) begin
               cnt_r[gc] <= cnt_r[gc] + 8'h01;
            end
         end

         always_ff @(posedge clk_i) begin
            if (reset_i) begin
               cora_r[gc] <= 8'hFF;
            end else if (wr_w[gc] && kind == `EBT_KIND_CONST_A) begin
               cora_r[gc] <= wdat;
            end
         end

         // Capture outranks a simultaneous software write.
         always_ff @(posedge clk_i) begin
            if (reset_i) begin
               corb_r[gc] <= 8'hFF;
            end else if (capld_w[gc]) begin
               corb_r[gc] <= cnt_r[gc];
            end else if (wr_w[gc] && kind == `EBT_KIND_CONST_B) begin
               corb_r[gc] <= wdat;
            end
         end

         // Control bits seven to five are not stored and read zero.
         always_ff @(posedge clk_i) begin
            if (reset_i) begin
               ctl_r[gc] <= `EBT_CTRL_RST;
            end else if (wr_w[gc] && kind == `EBT_KIND_CTRL) begin
               ctl_r[gc] <= wdat[4:0];
            end
         end

         // The write mask keeps channel two's bit four at one.
         always_ff @(posedge clk_i) begin
            if (reset_i) begin
               cfg_r[gc] <= CFG_RST;
            end else if (wr_w[gc] && kind == `EBT_KIND_STATUS) begin
               cfg_r[gc] <= (wdat[4:0] & CFG_WM) | (cfg_r[gc] & ~CFG_WM);
            end
         end

         // Flags order is {match B, match A, wrap}; a set beats a clear.
         assign set_f  = {mb_w[gc] | capld_w[gc], ma_w[gc], ovf_w[gc]};
         assign sw_clr = (wr_w[gc] && kind == `EBT_KIND_STATUS) ?
                         (arm_r[gc] & ~wdat[7:5]) : 3'h0;

         always_ff @(posedge clk_i) begin
            if (reset_i) begin
               flag_r[gc] <= 3'h0;
            end else begin
               flag_r[gc] <= (flag_r[gc] & ~sw_clr) | set_f;
            end
         end

         // A flag may be cleared only after software has seen it set.
         always_ff @(posedge clk_i) begin
            if (reset_i) begin
               arm_r[gc] <= 3'h0;
            end else if (rdcap_w[gc]) begin
               arm_r[gc] <= flag_r[gc];
            end else begin
               arm_r[gc] <= arm_r[gc] & ~sw_clr;
            end
         end

         // Action codes rise with priority, so the larger one wins.
         assign act_a = ma_w[gc] ? cfg_r[gc][1:0] : `EBT_ACT_NONE;
         assign act_b = mb_w[gc] ? cfg_r[gc][3:2] : `EBT_ACT_NONE;
         assign act   = (act_a > act_b) ? act_a : act_b;

         always_ff @(posedge clk_i) begin
            if (reset_i) begin
               timer_output_pin_o[gc] <= 1'b0;
            end else if (!cap_pin_w[gc]) begin
               case (act)
                  `EBT_ACT_ZERO:   timer_output_pin_o[gc] <= 1'b0;
                  `EBT_ACT_ONE:    timer_output_pin_o[gc] <= 1'b1;
                  `EBT_ACT_TOGGLE: timer_output_pin_o[gc] <=
                                      ~timer_output_pin_o[gc];
                  default:         timer_output_pin_o[gc] <=
                                      timer_output_pin_o[gc];
               endcase
            end
         end

         // Odd pins turn into inputs while register B captures.
         assign timer_output_oe_n_o[gc] = (cfg_r[gc][3:0] == 4'h0) |
                                          cap_pin_w[gc];
      end
   endgenerate

endmodule : ebt_timer

// ---- bench/ebt_timer_monitor.sv ----
// Concurrent checks on the ports of the paired eight-bit timer.
module ebt_timer_monitor
   import ebt_pkg::*;
(
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   input  wire ebt_avs_req_t avs_req_i,
   input  wire logic [31:0]  avs_readdata_o,
   input  wire logic         avs_waitrequest_o,
   input  wire logic [1:0]   ext_count_clk_i,
   input  wire logic [1:0]   capture_or_output_pin_i,
   input  wire logic [3:0]   timer_output_pin_o,
   input  wire logic [3:0]   timer_output_oe_n_o
);
   default clocking mon_cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   logic [4:0] cfg_r [4];
   logic       st_w;
   logic       unmapped;
   logic       rd_take;
   logic [3:0] rise_ok;
   logic [3:0] fall_ok;
   logic [3:0] dis;

   assign rd_take  = avs_req_i.read && !avs_waitrequest_o;
   assign unmapped = avs_req_i.address[7:6] != 2'h0
                  || avs_req_i.address[1:0] != 2'h0
                  || avs_req_i.address[4:2] > 3'h4;
   assign st_w = avs_req_i.write && !avs_waitrequest_o && !unmapped
              && avs_req_i.address[4:2] == 3'h4;

   // Shadow of the action and capture enable bits, updated when a status
   // write is taken, so output behaviour can be judged from the bus alone.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         for (int c = 0; c < 4; c++) cfg_r[c] <= 5'h00;
      end else if (st_w) begin
         if (avs_req_i.byteenable[1])
            cfg_r[{avs_req_i.address[5], 1'b0}] <= avs_req_i.writedata[12:8];
         if (avs_req_i.byteenable[0])
            cfg_r[{avs_req_i.address[5], 1'b1}] <= avs_req_i.writedata[4:0];
      end
   end

   always_comb begin
      logic b_on;
      b_on = 1'b0;
      for (int c = 0; c < 4; c++) begin
         b_on = !cfg_r[c | 1][4];
         rise_ok[c] = cfg_r[c][1] | (b_on & cfg_r[c][3]);
         fall_ok[c] = cfg_r[c][0] | (b_on & cfg_r[c][2]);
         dis[c] = cfg_r[c][3:0] == 4'h0 || (c % 2 == 1 && cfg_r[c][4]);
      end
   end

   wait_once_a: assert property (
      $rose(avs_req_i.read || avs_req_i.write)
      |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("bus answer not after exactly one wait cycle");
   idle_wait_a: assert property (
      !(avs_req_i.read || avs_req_i.write) |-> !avs_waitrequest_o)
      else $error("waitrequest high with no request");
   unmapped_zero_a: assert property (
      rd_take && unmapped |-> avs_readdata_o == 32'h0000_0000)
      else $error("unmapped read returned nonzero data");
   upper_zero_a: assert property (
      rd_take |-> avs_readdata_o[31:16] == 16'h0000)
      else $error("upper read lanes not zero");
   data_stands_a: assert property (
      !avs_req_i.read |=> $stable(avs_readdata_o))
      else $error("read data changed without a read");

   for (genvar g = 0; g < 4; g++) begin : g_ch
      oe_follow_a: assert property (
         timer_output_oe_n_o[g] == dis[g])
         else $error("output enable does not follow action bits");
      rise_cause_a: assert property (
         $rose(timer_output_pin_o[g]) && !$past(reset_i) |-> $past(rise_ok[g]))
         else $error("output rose with no drive-one or toggle action");
      fall_cause_a: assert property (
         $fell(timer_output_pin_o[g]) && !$past(reset_i) |-> $past(fall_ok[g]))
         else $error("output fell with no drive-zero or toggle action");
      hold_dis_a: assert property (
         $past(timer_output_oe_n_o[g]) && timer_output_oe_n_o[g]
         && !$past(reset_i) |-> $stable(timer_output_pin_o[g]))
         else $error("disabled output changed");
   end

   cover property (rd_take && unmapped);
   cover property (st_w);
   cover property ($rose(timer_output_pin_o[1]));
endmodule : ebt_timer_monitor

bind ebt_timer ebt_timer_monitor u_ebt_timer_monitor (
   .clk_i, .reset_i, .avs_req_i, .avs_readdata_o, .avs_waitrequest_o,
   .ext_count_clk_i, .capture_or_output_pin_i, .timer_output_pin_o,
   .timer_output_oe_n_o
);

// ---- bench/ebt_cpu_model.sv ----
// Bus master model of the processor that reaches the timer registers.
module ebt_cpu_model
   import ebt_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        waitrequest_i,
   input  wire logic [31:0] readdata_i,
   output ebt_avs_req_t     req_o
);
   timeunit 1ns;
   timeprecision 100ps;

   initial req_o = '0;

   // Holds the request until waitrequest is seen low at an edge, then
   // releases it and scrambles the data so stale values are never trusted.
   task automatic wait_taken;
      do @(posedge clk_i); while (waitrequest_i !== 1'b0);
      req_o.read      <= 1'b0;
      req_o.write     <= 1'b0;
      req_o.writedata <= ~req_o.writedata;
   endtask : wait_taken

   task automatic bus_write(input logic [7:0] a, input logic [15:0] d,
                            input logic [1:0] be);
      @(posedge clk_i);
      req_o <= '{address: a, read: 1'b0, write: 1'b1,
                 writedata: {16'h0000, d}, byteenable: {2'b00, be}};
      wait_taken();
   endtask : bus_write

   task automatic bus_read(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk_i);
      req_o <= '{address: a, read: 1'b1, write: 1'b0,
                 writedata: 32'h0000_0000, byteenable: 4'h3};
      wait_taken();
      d = readdata_i[15:0];
   endtask : bus_read
endmodule : ebt_cpu_model

// ---- bench/ebt_timer_bench.sv ----
// Self-checking testbench of the paired eight-bit timer.
module ebt_timer_bench;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct {
      logic wr; logic [7:0] addr; logic [15:0] data;
      logic [1:0] be; logic [15:0] exp;
   } ebt_row_t;

   logic                  clk_i;
   logic                  reset_i;
   logic [1:0]            ext_clk;
   logic [1:0]            cap_pin;
   wire logic [31:0]      rdata;
   wire logic             waitreq;
   wire logic [3:0]       pin;
   wire logic [3:0]       oe_n;
   ebt_pkg::ebt_avs_req_t req;
   int                    errors = 0;
   int                    check_count = 0;
   int                    cycles = 0;
   int                    n;

   ebt_row_t rows [16] = '{
      '{0, 8'h00, 16'h0000, 2'h0, 16'h0000}, '{0, 8'h04, 16'h0000, 2'h0, 16'hFFFF},
      '{0, 8'h08, 16'h0000, 2'h0, 16'hFFFF}, '{0, 8'h0C, 16'h0000, 2'h0, 16'h0000},
      '{0, 8'h10, 16'h0000, 2'h0, 16'h0000}, '{0, 8'h30, 16'h0000, 2'h0, 16'h1000},
      '{0, 8'h14, 16'h0000, 2'h0, 16'h0000}, '{0, 8'h41, 16'h0000, 2'h0, 16'h0000},
      '{1, 8'h04, 16'h1234, 2'h3, 16'h1234}, '{1, 8'h08, 16'h00AB, 2'h1, 16'hFFAB},
      '{1, 8'h0C, 16'hFFFF, 2'h3, 16'h1F1F}, '{1, 8'h30, 16'h0000, 2'h3, 16'h1000},
      '{1, 8'h34, 16'h5555, 2'h3, 16'h0000}, '{1, 8'h0C, 16'h0000, 2'h3, 16'h0000},
      '{1, 8'h10, 16'hFFFF, 2'h3, 16'h1F1F}, '{1, 8'h10, 16'h0000, 2'h3, 16'h0000}};

   ebt_timer u_ebt_timer (
      .clk_i                   (clk_i),
      .reset_i                 (reset_i),
      .avs_req_i               (req),
      .avs_readdata_o          (rdata),
      .avs_waitrequest_o       (waitreq),
      .ext_count_clk_i         (ext_clk),
      .capture_or_output_pin_i (cap_pin),
      .timer_output_pin_o      (pin),
      .timer_output_oe_n_o     (oe_n)
   );

   ebt_cpu_model u_ebt_cpu_model (
      .clk_i         (clk_i),
      .waitrequest_i (waitreq),
      .readdata_i    (rdata),
      .req_o         (req)
   );

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : conclude

   // A hang in a bus wait ends here rather than stalling the run.
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         conclude();
      end
   end

   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] d;
      u_ebt_cpu_model.bus_read(a, d);
      chk($sformatf("reg_%h", a), exp, d);
   endtask : rd_chk

   task automatic wr(input logic [7:0] a, input logic [15:0] d,
                     input logic [1:0] be);
      u_ebt_cpu_model.bus_write(a, d, be);
   endtask : wr

   // High levels last four system clocks and lows five, well above the minimum pulse width.
   task automatic pulses(input int idx, input int cnt);
      repeat (cnt) begin
         @(posedge clk_i) ext_clk[idx] <= 1'b1;
         repeat (4) @(posedge clk_i);
         ext_clk[idx] <= 1'b0;
         repeat (4) @(posedge clk_i);
      end
      repeat (6) @(posedge clk_i);
   endtask : pulses

   initial begin
      reset_i = 1'b1;
      ext_clk = 2'b00;
      cap_pin = 2'b00;
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].addr, rows[i].data, rows[i].be);
         rd_chk(rows[i].addr, rows[i].exp);
      end
      // Divide by eight, clear and toggle on match A at count three.
      wr(8'h04, 16'h0003, 2'b01);
      wr(8'h10, 16'h0003, 2'b01);
      wr(8'h0C, 16'h0009, 2'b01);
      n = 0;
      while (pin[1] !== 1'b1 && n < 200) begin @(posedge clk_i); n++; end
      n = 0;
      while (pin[1] !== 1'b0 && n < 200) begin @(posedge clk_i); n++; end
      chk("toggle_period", 16'h0020, n[15:0]);
      wr(8'h0C, 16'h0008, 2'b01);
      rd_chk(8'h10, 16'h0043);
      wr(8'h10, 16'h00E3, 2'b01);
      rd_chk(8'h10, 16'h0043);
      wr(8'h10, 16'h0003, 2'b01);
      rd_chk(8'h10, 16'h0003);
      // Sixteen-bit cascade on the second pair, lower byte on rising edges.
      wr(8'h24, 16'h12FF, 2'b11);
      wr(8'h20, 16'hFFFE, 2'b11);
      wr(8'h2C, 16'h0405, 2'b11);
      pulses(1, 2);
      rd_chk(8'h20, 16'h0000);
      rd_chk(8'h30, 16'hB0E0);
      // Matches A and B together on the lower byte: toggle beats zero.
      wr(8'h20, 16'h00FE, 2'b11);
      wr(8'h30, 16'h000D, 2'b01);
      pulses(1, 2);
      chk("priority_pin", 16'h0001, {15'h0000, pin[3]});
      // Channel three counts channel two match A.
      wr(8'h20, 16'h0000, 2'b11);
      wr(8'h24, 16'h01FF, 2'b11);
      wr(8'h2C, 16'h0D04, 2'b11);
      pulses(1, 4);
      rd_chk(8'h20, 16'h0002);
      // Capture on the falling edge, counter cleared by the capture.
      wr(8'h00, 16'h0000, 2'b11);
      wr(8'h10, 16'h0014, 2'b01);
      wr(8'h0C, 16'h001D, 2'b01);
      pulses(0, 5);
      @(posedge clk_i) cap_pin <= 2'b01;
      repeat (6) @(posedge clk_i);
      cap_pin <= 2'b00;
      repeat (6) @(posedge clk_i);
      rd_chk(8'h08, 16'hFF05);
      rd_chk(8'h00, 16'h0000);
      rd_chk(8'h10, 16'h00D4);
      conclude();
   end
endmodule : ebt_timer_bench
